// file: src/fpc_top.sv
// Flash program control: register front end, unlock, error flags, interrupt
`timescale 1ns/1ns
module fpc_top (
    input wire logic mclk_i,              // System clock, 250 MHz
    input wire logic rst_n_i,             // Device reset, active low
    input wire logic por_n_i,             // Power-on reset, active low
    input wire logic wb_cyc_i,            // Wishbone cycle
    input wire logic wb_stb_i,            // Wishbone strobe
    input wire logic wb_we_i,             // Wishbone write
    input wire logic [7:0] wb_adr_i,      // Wishbone byte address
    input wire logic [3:0] wb_sel_i,      // Wishbone byte selects
    input wire logic [31:0] wb_dat_i,     // Wishbone write data
    output logic [31:0] wb_dat_o,         // Wishbone read data
    output logic wb_ack_o,                // Wishbone acknowledge
    output logic flash_req_o,             // Array operation request, held
    output logic [1:0] flash_cmd_o,       // Array command
    input wire logic flash_ack_i,         // Array finished, pulse
    input wire logic flash_err_i,         // Array failure, with ack
    input wire logic target_protected_i,  // Target location protected
    input wire logic any_protected_i,     // Some page protected
    input wire logic low_voltage_i,       // Detector raw output
    output logic lvd_enable_o,            // Low-voltage detector enable
    output logic irq_o                    // Interrupt, level
);
    import fpc_pkg::*;

    // Survives device reset
    typedef struct packed {
        logic start;
        logic [3:0] flash_op_select;
        logic flash_write_error;
        logic low_voltage_error;
    } fpc_keep_s;

    // Cleared by device reset
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic flash_write_enable;
        logic [1:0] key;
        logic low_voltage_status;
        logic [EV_W-1:0] stat;
        logic [EV_W-1:0] mask;
        logic irq;
    } fpc_dev_s;

    fpc_keep_s k_reg;
    fpc_keep_s k_next;
    fpc_dev_s d_reg;
    fpc_dev_s d_next;
    fpc_seq_if sq ();

    logic req;
    logic wr_edge;
    logic wr_ctrl;
    logic launch;
    logic [31:0] ctrl_view;
    logic [EV_W-1:0] ev;

    fpc_seq u_seq (
        .mclk_i(mclk_i),
        .por_n_i(por_n_i),
        .sq(sq)
    );

    // detector only armed with write enable
    assign sq.lv_abort = low_voltage_i & d_reg.flash_write_enable;
    assign sq.arr_ack = flash_ack_i;
    assign sq.arr_err = flash_err_i;
    assign sq.tgt_prot = target_protected_i;
    assign sq.any_prot = any_protected_i;
    assign sq.op = k_reg.flash_op_select;
    assign sq.start = launch;

    assign req = wb_cyc_i & wb_stb_i;
    // Writes land on the edge where the master sees ack
    assign wr_edge = req & wb_we_i & d_reg.ack;
    assign wr_ctrl = wr_edge && (wb_adr_i == ADR_CTRL) && wb_sel_i[1];
    // start needs enable, fresh unlock, idle
    assign launch = wr_ctrl && wb_dat_i[BIT_START] && d_reg.flash_write_enable
                    && (d_reg.key == KEY_OPEN) && !k_reg.start;

    always_comb
    begin
        ctrl_view = DAT_RESET;
        ctrl_view[BIT_START] = k_reg.start;
        ctrl_view[BIT_FLASH_WRITE_ENABLE] = d_reg.flash_write_enable;
        ctrl_view[BIT_WERR] = k_reg.flash_write_error;
        ctrl_view[BIT_LVERR] = k_reg.low_voltage_error;
        ctrl_view[BIT_LVSTAT] = d_reg.low_voltage_status;
        ctrl_view[3:0] = k_reg.flash_op_select;
    end

    always_comb
    begin
        k_next = k_reg;
        d_next = d_reg;
        ev = EV_RESET;
        d_next.ack = req & ~d_reg.ack;
        if (req && !d_reg.ack && !wb_we_i)
        begin
            if (wb_adr_i == ADR_CTRL)
                d_next.dat = ctrl_view;
            else if (wb_adr_i == ADR_STAT)
                d_next.dat = {29'h0, d_reg.stat};
            else if (wb_adr_i == ADR_MASK)
                d_next.dat = {29'h0, d_reg.mask};
            else
                d_next.dat = DAT_RESET;
        end
        // Unlock holds only for the very next write
        if (wr_edge)
        begin
            if (wb_adr_i == ADR_KEY && wb_sel_i == 4'hf && wb_dat_i == UNLOCK_KEY1)
                d_next.key = KEY_HALF;
            else if (wb_adr_i == ADR_KEY && wb_sel_i == 4'hf && wb_dat_i == UNLOCK_KEY2
                     && d_reg.key == KEY_HALF)
                d_next.key = KEY_OPEN;
            else
                d_next.key = KEY_IDLE;
        end
        if (wr_ctrl)
            d_next.flash_write_enable = wb_dat_i[BIT_FLASH_WRITE_ENABLE];
        if (wr_edge && wb_adr_i == ADR_CTRL && wb_sel_i[0] && !d_reg.flash_write_enable)
            k_next.flash_op_select = wb_dat_i[3:0];
        if (wr_edge && wb_adr_i == ADR_MASK && wb_sel_i[0])
            d_next.mask = wb_dat_i[EV_W-1:0];
        // set on launch, cleared by completion
        if (launch)
            k_next.start = 1'b1;
        else if (sq.done)
            k_next.start = 1'b0;
        // clear both flags on code zero start
        if (launch && k_reg.flash_op_select == OP_CLEAR)
        begin
            k_next.flash_write_error = 1'b0;
            k_next.low_voltage_error = 1'b0;
        end
        if (sq.done && sq.fail)
            k_next.flash_write_error = 1'b1;
        if (k_reg.start && sq.lv_abort)
            k_next.low_voltage_error = 1'b1;
        d_next.low_voltage_status = sq.lv_abort;
        ev[EV_DONE] = sq.done;
        ev[EV_WERR] = k_next.flash_write_error & ~k_reg.flash_write_error;
        ev[EV_LVERR] = k_next.low_voltage_error & ~k_reg.low_voltage_error;
        // Set wins over a same-cycle clear
        if (wr_edge && wb_adr_i == ADR_STAT && wb_sel_i[0])
            d_next.stat = (d_reg.stat & ~wb_dat_i[EV_W-1:0]) | ev;
        else
            d_next.stat = d_reg.stat | ev;
        d_next.irq = |(d_next.stat & d_next.mask);
    end

    always_ff @(posedge mclk_i or negedge por_n_i)
    begin
        if (!por_n_i)
            k_reg <= '{start: 1'b0, flash_op_select: OP_CLEAR, flash_write_error: 1'b0, low_voltage_error: 1'b0};
        else
            k_reg <= k_next;
    end

    // only this group sees device reset
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            d_reg <= '{ack: 1'b0, dat: DAT_RESET, flash_write_enable: 1'b0, key: KEY_IDLE,
                       low_voltage_status: 1'b0, stat: EV_RESET, mask: EV_RESET, irq: 1'b0};
        else
            d_reg <= d_next;
    end

    assign wb_ack_o = d_reg.ack;
    assign wb_dat_o = d_reg.dat;
    assign lvd_enable_o = d_reg.flash_write_enable;
    assign irq_o = d_reg.irq;
    assign flash_req_o = sq.arr_req;
    assign flash_cmd_o = sq.arr_cmd;

    property p_start_gate;
        @(posedge mclk_i) disable iff (!rst_n_i || !por_n_i)
        $rose(k_reg.start) |-> $past(d_reg.flash_write_enable) && $past(d_reg.key) == KEY_OPEN;
    endproperty
    a_start_gate: assert property (p_start_gate) else $error("start set without enable and unlock");

    property p_start_clear;
        @(posedge mclk_i) disable iff (!rst_n_i || !por_n_i)
        sq.done |=> !k_reg.start;
    endproperty
    a_start_clear: assert property (p_start_clear) else $error("start bit not cleared after completion");

    property p_nop_finish;
        @(posedge mclk_i) disable iff (!rst_n_i || !por_n_i)
        (launch && !fpc_op_real(k_reg.flash_op_select)) |=> k_reg.start ##2 !k_reg.start;
    endproperty
    a_nop_finish: assert property (p_nop_finish) else $error("no-op did not finish in two cycles");

    property p_keep_over_reset;
        @(posedge mclk_i) disable iff (!por_n_i)
        $fell(rst_n_i) |=> k_reg.flash_op_select == $past(k_reg.flash_op_select, 2) || $past(k_reg.start, 2);
    endproperty
    a_keep_over_reset: assert property (p_keep_over_reset) else $error("op select lost on device reset");

    property p_lvd_enable;
        @(posedge mclk_i) disable iff (!rst_n_i)
        !lvd_enable_o |=> !d_reg.low_voltage_status || lvd_enable_o;
    endproperty
    a_lvd_enable: assert property (p_lvd_enable) else $error("detector status while disabled");

    property p_werr_set;
        @(posedge mclk_i) disable iff (!rst_n_i || !por_n_i)
        (sq.done && sq.fail) |=> k_reg.flash_write_error
            && (d_reg.stat[EV_WERR] || $past(k_reg.flash_write_error));
    endproperty
    a_werr_set: assert property (p_werr_set) else $error("write error not flagged on failure");

    property p_lverr_set;
        @(posedge mclk_i) disable iff (!rst_n_i || !por_n_i)
        (k_reg.start && low_voltage_i && d_reg.flash_write_enable) |=> k_reg.low_voltage_error;
    endproperty
    a_lverr_set: assert property (p_lverr_set) else $error("low-voltage error missed");

    property p_lvstat_live;
        @(posedge mclk_i) disable iff (!rst_n_i)
        ##1 d_reg.low_voltage_status == $past(low_voltage_i & d_reg.flash_write_enable);
    endproperty
    a_lvstat_live: assert property (p_lvstat_live) else $error("status does not track detector");

    property p_op_frozen;
        @(posedge mclk_i) disable iff (!rst_n_i || !por_n_i)
        d_reg.flash_write_enable |=> $stable(k_reg.flash_op_select);
    endproperty
    a_op_frozen: assert property (p_op_frozen) else $error("op select changed while enabled");

    property p_err_clear_only;
        @(posedge mclk_i) disable iff (!rst_n_i || !por_n_i)
        $fell(k_reg.flash_write_error) |-> $past(launch) && $past(k_reg.flash_op_select) == OP_CLEAR;
    endproperty
    a_err_clear_only: assert property (p_err_clear_only) else $error("error flag cleared without code zero");

    property p_ack_one;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (req && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack not a single cycle after request");

    property p_irq_level;
        @(posedge mclk_i) disable iff (!rst_n_i)
        ##1 irq_o == |($past(d_next.stat) & $past(d_next.mask));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt does not follow status and mask");

    property p_key_shut;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (wr_edge && wb_adr_i != ADR_KEY) |=> d_reg.key == KEY_IDLE;
    endproperty
    a_key_shut: assert property (p_key_shut) else $error("unlock kept");

    property p_req_held;
        @(posedge mclk_i) disable iff (!por_n_i)
        (flash_req_o && !flash_ack_i && !sq.lv_abort) |=> flash_req_o;
    endproperty
    a_req_held: assert property (p_req_held) else $error("request dropped");

    property p_lv_cut;
        @(posedge mclk_i) disable iff (!rst_n_i || !por_n_i)
        (flash_req_o && sq.lv_abort) |=> !flash_req_o && k_reg.low_voltage_error;
    endproperty
    a_lv_cut: assert property (p_lv_cut) else $error("supply cut missed");

    property p_err_wipe;
        @(posedge mclk_i) disable iff (!rst_n_i || !por_n_i)
        (launch && k_reg.flash_op_select == OP_CLEAR) |=> !k_reg.flash_write_error && !k_reg.low_voltage_error;
    endproperty
    a_err_wipe: assert property (p_err_wipe) else $error("flags not wiped");

    property p_tgt_block;
        @(posedge mclk_i) disable iff (!rst_n_i || !por_n_i)
        (launch && fpc_op_real(k_reg.flash_op_select) && k_reg.flash_op_select != OP_FULL) ##1 target_protected_i
            |=> !flash_req_o && sq.fail;
    endproperty
    a_tgt_block: assert property (p_tgt_block) else $error("protected target run");

    property p_row_cmd;
        @(posedge mclk_i) disable iff (!rst_n_i || !por_n_i)
        (launch && k_reg.flash_op_select == OP_ROW) ##1 !target_protected_i
            |=> flash_req_o && flash_cmd_o == CMD_ROW;
    endproperty
    a_row_cmd: assert property (p_row_cmd) else $error("row command wrong");

    c_launch_real: cover property (@(posedge mclk_i) disable iff (!rst_n_i) launch && fpc_op_real(k_reg.flash_op_select));
    c_array_done: cover property (@(posedge mclk_i) disable iff (!rst_n_i) flash_req_o && flash_ack_i);
    c_lv_abort: cover property (@(posedge mclk_i) disable iff (!rst_n_i) flash_req_o && sq.lv_abort);
    c_clear_errs: cover property (@(posedge mclk_i) disable iff (!rst_n_i) $fell(k_reg.low_voltage_error));
    c_refused: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        sq.done && sq.fail);
endmodule : fpc_top

// file: src/fpc_pkg.sv
// Constants, types and helpers shared by the flash program control block
// How it works
// - Start bit accepts a one only with write enable set and unlock just done.
// - Start launches the chosen operation; hardware clears start bit when finished.
// - Device reset returns only the write-enable and low-voltage status bits of the control register.
// - Write enable permits start writes and switches on the low-voltage detector.
// - Write-error flag is set by hardware when program or erase fails.
// - Low-voltage error flag set on low supply during an operation, detector enabled.
// - Low-voltage status follows the detector live while the detector is enabled.
// - Operation select field is writable only while write enable is zero.
// - Code 0001 programs one word unless that location is protected.
// - Code 0011 programs one row unless that row is protected.
// - Code 0100 erases one page unless that page is protected.
// - Code 0101 erases the whole array only when no page is protected.
// - Both error flags clear only by starting an operation with code zero.
package fpc_pkg;
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_KEY = 8'h04;
    localparam logic [7:0] ADR_STAT = 8'h08;
    localparam logic [7:0] ADR_MASK = 8'h0c;
    localparam int BIT_START = 15;
    localparam int BIT_FLASH_WRITE_ENABLE = 14;
    localparam int BIT_WERR = 13;
    localparam int BIT_LVERR = 12;
    localparam int BIT_LVSTAT = 11;
    localparam logic [3:0] OP_CLEAR = 4'h0;
    localparam logic [3:0] OP_WORD = 4'h1;
    localparam logic [3:0] OP_ROW = 4'h3;
    localparam logic [3:0] OP_PAGE = 4'h4;
    localparam logic [3:0] OP_FULL = 4'h5;
    localparam logic [1:0] CMD_WORD = 2'h0;
    localparam logic [1:0] CMD_ROW = 2'h1;
    localparam logic [1:0] CMD_PAGE = 2'h2;
    localparam logic [1:0] CMD_FULL = 2'h3;
    // Key values are arbitrary
    localparam logic [31:0] UNLOCK_KEY1 = 32'h0000_5a5a;
    localparam logic [31:0] UNLOCK_KEY2 = 32'h0000_a5a5;
    localparam int EV_DONE = 0;
    localparam int EV_WERR = 1;
    localparam int EV_LVERR = 2;
    localparam int EV_W = 3;
    localparam logic [EV_W-1:0] EV_RESET = 3'h0;
    localparam logic [31:0] DAT_RESET = 32'h0000_0000;
    localparam logic [1:0] KEY_IDLE = 2'h0;
    localparam logic [1:0] KEY_HALF = 2'h1;
    localparam logic [1:0] KEY_OPEN = 2'h2;

    typedef enum logic [3:0] {
        SEQ_IDLE = 4'b0001,
        SEQ_CHECK = 4'b0010,
        SEQ_RUN = 4'b0100,
        SEQ_DONE = 4'b1000
    } fpc_seq_state_e;

    // True for codes that touch the array
    function automatic logic fpc_op_real(input logic [3:0] op);
        fpc_op_real = (op == OP_WORD) || (op == OP_ROW) || (op == OP_PAGE) || (op == OP_FULL);
    endfunction : fpc_op_real

    function automatic logic [1:0] fpc_op_cmd(input logic [3:0] op);
        if (op == OP_ROW)
            fpc_op_cmd = CMD_ROW;
        else if (op == OP_PAGE)
            fpc_op_cmd = CMD_PAGE;
        else if (op == OP_FULL)
            fpc_op_cmd = CMD_FULL;
        else
            fpc_op_cmd = CMD_WORD;
    endfunction : fpc_op_cmd
endpackage : fpc_pkg

// file: src/fpc_seq_if.sv
// Link between register front end and operation sequencer
`timescale 1ns/1ns
interface fpc_seq_if;
    logic start;
    logic [3:0] op;
    logic lv_abort;
    logic done;
    logic fail;
    logic arr_req;
    logic [1:0] arr_cmd;
    logic arr_ack;
    logic arr_err;
    logic tgt_prot;
    logic any_prot;

    modport ctl (output start, op, lv_abort, arr_ack, arr_err, tgt_prot, any_prot,
                 input done, fail, arr_req, arr_cmd);
    modport seq (input start, op, lv_abort, arr_ack, arr_err, tgt_prot, any_prot,
                 output done, fail, arr_req, arr_cmd);
endinterface : fpc_seq_if

// file: src/fpc_seq.sv
// Operation sequencer driving the flash array request
`timescale 1ns/1ns
module fpc_seq (
    input wire logic mclk_i,     // System clock
    input wire logic por_n_i,    // Power-on reset, active low
    fpc_seq_if.seq sq            // Control link
);
    import fpc_pkg::*;

    typedef struct packed {
        fpc_seq_state_e state;
        logic [3:0] op;
        logic arr_req;
        logic [1:0] arr_cmd;
        logic done;
        logic fail;
    } fpc_seq_s;

    fpc_seq_s s_reg;
    fpc_seq_s s_next;

    always_comb
    begin
        s_next = s_reg;
        s_next.done = 1'b0;
        case (s_reg.state)
            SEQ_IDLE:
            begin
                s_next.fail = 1'b0;
                if (sq.start)
                begin
                    s_next.op = sq.op;
                    s_next.state = SEQ_CHECK;
                end
            end
            SEQ_CHECK:
            begin
                s_next.state = SEQ_DONE;
                s_next.done = 1'b1;
                if (!fpc_op_real(s_reg.op))
                    s_next.fail = 1'b0;
                else if (s_reg.op == OP_FULL && sq.any_prot)
                    s_next.fail = 1'b1;
                else if (s_reg.op != OP_FULL && sq.tgt_prot)
                    s_next.fail = 1'b1;
                else
                begin
                    s_next.done = 1'b0;
                    s_next.arr_req = 1'b1;
                    s_next.arr_cmd = fpc_op_cmd(s_reg.op);
                    s_next.state = SEQ_RUN;
                end
            end
            SEQ_RUN:
            begin
                // Low supply aborts rather than risk a half-written cell
                if (sq.lv_abort || sq.arr_ack)
                begin
                    s_next.arr_req = 1'b0;
                    s_next.done = 1'b1;
                    s_next.fail = sq.lv_abort | sq.arr_err;
                    s_next.state = SEQ_DONE;
                end
            end
            default:
                s_next.state = SEQ_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i or negedge por_n_i)
    begin
        if (!por_n_i)
            s_reg <= '{state: SEQ_IDLE, op: OP_CLEAR, arr_req: 1'b0, arr_cmd: CMD_WORD, done: 1'b0, fail: 1'b0};
        else
            s_reg <= s_next;
    end

    assign sq.done = s_reg.done;
    assign sq.fail = s_reg.fail;
    assign sq.arr_req = s_reg.arr_req;
    assign sq.arr_cmd = s_reg.arr_cmd;

    property p_prot_no_req;
        @(posedge mclk_i) disable iff (!por_n_i)
        (s_reg.state == SEQ_CHECK && s_reg.op == OP_FULL && sq.any_prot) |=> !s_reg.arr_req && s_reg.fail;
    endproperty
    a_prot_no_req: assert property (p_prot_no_req) else $error("full erase issued with protected page");

    property p_nop_quiet;
        @(posedge mclk_i) disable iff (!por_n_i)
        (s_reg.state == SEQ_CHECK && !fpc_op_real(s_reg.op)) |=> s_reg.done && !s_reg.arr_req && !s_reg.fail;
    endproperty
    a_nop_quiet: assert property (p_nop_quiet) else $error("no-op code touched the array");
endmodule : fpc_seq

// file: verif/fpc_flash_model.sv
// Behavioural model of the program flash array behind the sequencer
`timescale 1ns/1ns
module fpc_flash_model (
    input wire logic mclk_i,         // System clock
    input wire logic rst_n_i,        // Power-on reset, active low
    input wire logic req_i,          // Operation request
    input wire logic [1:0] cmd_i,    // Operation command
    input wire logic [3:0] delay_i,  // Busy cycles before finishing
    input wire logic fail_i,         // Report failure on finishing
    output logic ack_o,              // Finished, one-cycle pulse
    output logic err_o,              // Failure, valid only with ack
    output logic [7:0] ops_o,        // Operations accepted
    output logic [1:0] last_cmd_o    // Command of last operation
);
    logic [1:0] phase_reg;
    logic [3:0] cnt_reg;

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            phase_reg <= 2'h0;
            cnt_reg <= 4'h0;
            ack_o <= 1'b0;
            err_o <= 1'b0;
            ops_o <= 8'h00;
            last_cmd_o <= 2'h0;
        end
        else
        begin
            ack_o <= 1'b0;
            // Error line carries junk outside ack so a stale sample shows
            err_o <= ~err_o;
            case (phase_reg)
                2'h0:
                    if (req_i)
                    begin
                        phase_reg <= 2'h1;
                        cnt_reg <= delay_i;
                        last_cmd_o <= cmd_i;
                        ops_o <= ops_o + 8'h01;
                    end
                2'h1:
                    // finish after busy time; abort on early release
                    if (!req_i)
                        phase_reg <= 2'h0;
                    else if (cnt_reg == 4'h0)
                    begin
                        ack_o <= 1'b1;
                        err_o <= fail_i;
                        phase_reg <= 2'h2;
                    end
                    else
                        cnt_reg <= cnt_reg - 4'h1;
                default:
                    if (!req_i)
                        phase_reg <= 2'h0;
            endcase
        end
    end
endmodule : fpc_flash_model

// file: verif/tb.sv
// Self-checking bench for the flash program control block
`timescale 1ns/1ns
module tb;
    import fpc_pkg::*;
    typedef struct {string name; logic [31:0] exp; logic [31:0] msk;} fpc_note_s;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b1;
    logic por_n_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, tp = 1'b0, ap = 1'b0, lv = 1'b0, mfail = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0, mdly = 4'h0;
    logic [31:0] dat = 32'h0, rdat, rq;
    logic ack, req, fack, ferr, lve, irq;
    logic [1:0] cmd, mcmd;
    logic [7:0] ops;
    int errors = 0, num_checks = 0, seed = 28284;
    fpc_note_s notes[$];
    fpc_note_s nt;

    always #2 mclk_i = ~mclk_i;

    fpc_top uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .por_n_i(por_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .flash_req_o(req), .flash_cmd_o(cmd), .flash_ack_i(fack), .flash_err_i(ferr),
        .target_protected_i(tp), .any_protected_i(ap), .low_voltage_i(lv), .lvd_enable_o(lve), .irq_o(irq));
    fpc_flash_model flash (.mclk_i(mclk_i), .rst_n_i(por_n_i), .req_i(req), .cmd_i(cmd), .delay_i(mdly),
        .fail_i(mfail), .ack_o(fack), .err_o(ferr), .ops_o(ops), .last_cmd_o(mcmd));

    task automatic give_verdict();
        if (errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // Read results are judged here, against the oldest note
    always @(posedge mclk_i)
    begin
        if (ack === 1'b1 && we === 1'b0 && notes.size() > 0)
        begin
            nt = notes.pop_front();
            check(nt.name, nt.exp & nt.msk, rdat & nt.msk);
        end
    end

    task automatic wb_io(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [31:0] q);
        int n;
        @(posedge mclk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        n = 0;
        do
        begin
            @(posedge mclk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 30);
        if (n >= 30)
            errors++;
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb_io

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] q;
        wb_io(1'b1, a, d, s, q);
    endtask : wr

    task automatic rd(input string name, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        notes.push_back('{name, e, m});
        wb_io(1'b0, a, 32'h0, 4'hf, rq);
    endtask : rd

    // Clear enable, choose code, enable, unlock, start, wait for finish
    task automatic run_op(input logic [3:0] code);
        int n;
        wr(ADR_CTRL, {28'h0, code}, 4'h3);
        wr(ADR_CTRL, {28'h0, code}, 4'h3);
        wr(ADR_CTRL, 32'h4000 | {28'h0, code}, 4'h3);
        wr(ADR_KEY, UNLOCK_KEY1, 4'hf);
        wr(ADR_KEY, UNLOCK_KEY2, 4'hf);
        wr(ADR_CTRL, 32'hc000 | {28'h0, code}, 4'h3);
        rq = 32'h8000;
        for (n = 0; n < 40 && rq[BIT_START] !== 1'b0; n++)
            rd("poll", ADR_CTRL, 32'h4000, 32'h4000);
        if (n >= 40)
            errors++;
    endtask : run_op

    initial
    begin
        repeat (60000) @(posedge mclk_i);
        errors++;
        give_verdict();
    end

    initial
    begin
        int i, n;
        logic [31:0] r, st;
        logic [3:0] code;
        logic [2:0] mk;
        logic [7:0] ops0;
        logic [7:0] radr [5];
        logic werr, prot, iss, nerr;
        radr = '{ADR_CTRL, ADR_KEY, ADR_STAT, ADR_MASK, 8'h10};
        werr = 1'b0;
        por_n_i = 1'b0;
        rst_n_i = 1'b0;
        repeat (6) @(posedge mclk_i);
        por_n_i <= 1'b1;
        rst_n_i <= 1'b1;
        for (i = 0; i < 5; i++)
            rd("reset read", radr[i], 32'h0, 32'hffff_ffff);
        wr(ADR_CTRL, 32'h1, 4'h3);
        wr(ADR_CTRL, 32'h4001, 4'h3);
        @(negedge mclk_i);
        check("lvd_enable_o", 32'h1, {31'h0, lve});
        wr(ADR_CTRL, 32'h4003, 4'h3);
        wr(ADR_CTRL, 32'hc001, 4'h3);
        rd("ctrl locked", ADR_CTRL, 32'h4001, 32'hffff_ffff);
        wr(ADR_KEY, UNLOCK_KEY1, 4'hf);
        wr(ADR_KEY, UNLOCK_KEY2, 4'hf);
        wr(ADR_MASK, 32'h0, 4'h1);
        wr(ADR_CTRL, 32'hc001, 4'h3);
        repeat (20) @(posedge mclk_i);
        rd("no start", ADR_STAT, 32'h0, 32'hffff_ffff);
        check("ops refused", 32'h0, {24'h0, ops});
        for (i = 0; i < 32; i++)
        begin
            code = i[3:0];
            r = $random(seed);
            mk = r[10:8];
            prot = (code == OP_FULL) ? r[1] : r[0];
            iss = (code == 4'h1 || code == 4'h3 || code == 4'h4 || code == 4'h5);
            prot = iss & prot;
            iss = iss & ~prot;
            nerr = prot | (iss & r[2]);
            st = {29'h0, 1'b0, nerr & ~werr, 1'b1};
            werr = (code == 4'h0) ? 1'b0 : (werr | nerr);
            @(posedge mclk_i);
            tp <= r[0];
            ap <= r[1];
            mfail <= r[2];
            mdly <= r[7:4];
            ops0 = ops;
            wr(ADR_MASK, {29'h0, mk}, 4'h1);
            run_op(code);
            check("ops", {24'h0, ops0 + {7'h0, iss}}, {24'h0, ops});
            if (iss)
                check("cmd", (code == 4'h3) ? 32'h1 : (code == 4'h4) ? 32'h2 : (code == 4'h5) ? 32'h3 : 32'h0,
                    {30'h0, mcmd});
            rd("ctrl", ADR_CTRL, 32'h4000 | {18'h0, werr, 9'h0, code}, 32'hffff_ffff);
            rd("status", ADR_STAT, st, 32'hffff_ffff);
            check("irq_o", {31'h0, |(st[2:0] & mk)}, {31'h0, irq});
            wr(ADR_STAT, 32'h7, 4'h1);
            repeat (2) @(posedge mclk_i);
            check("irq_o clear", 32'h0, {31'h0, irq});
        end
        @(posedge mclk_i);
        tp <= 1'b0;
        mdly <= 4'hf;
        fork
            run_op(4'h1);
            begin
                for (n = 0; n < 100 && req !== 1'b1; n++)
                    @(posedge mclk_i);
                lv <= 1'b1;
            end
        join
        rd("ctrl low", ADR_CTRL, 32'h7801, 32'hffff_ffff);
        @(posedge mclk_i);
        lv <= 1'b0;
        repeat (3) @(posedge mclk_i);
        rd("ctrl recovered", ADR_CTRL, 32'h7001, 32'hffff_ffff);
        rd("status low", ADR_STAT, werr ? 32'h5 : 32'h7, 32'hffff_ffff);
        @(posedge mclk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rd("ctrl after reset", ADR_CTRL, 32'h3001, 32'hffff_ffff);
        check("lvd_enable_o off", 32'h0, {31'h0, lve});
        @(posedge mclk_i);
        lv <= 1'b1;
        repeat (3) @(posedge mclk_i);
        rd("detector off", ADR_CTRL, 32'h3001, 32'hffff_ffff);
        @(posedge mclk_i);
        lv <= 1'b0;
        run_op(4'h0);
        rd("errors cleared", ADR_CTRL, 32'h4000, 32'hffff_ffff);
        give_verdict();
    end
endmodule : tb
